// *** design/cfg_seq_pkg.sv ***
// shared constants and types for the configuration-mode sequencer ends
package cfg_seq_pkg;

  localparam int unsigned clock_mhz = 100;
  localparam int unsigned data_w = 18;
  localparam int unsigned addr_w = 14;
  localparam int unsigned cfg_w = 8;
  localparam int unsigned cnt_w = 20;

  // timings in their own units
  localparam int unsigned t_cfgs_cyc = 32;
  localparam int unsigned t_cfgh_cyc = 32;
  localparam int unsigned t_cfgh_odt_cyc = 4096;
  localparam int unsigned t_cfgh_pll_us = 100;
  localparam int unsigned t_cfgd_cyc = 80;
  localparam int unsigned t_clds_cyc = 32;
  localparam int unsigned t_cldh_cyc = 32;
  localparam int unsigned t_cfga_cyc = 16;
  localparam int unsigned t_cldw_cyc = 16;
  localparam int unsigned t_crdl_cyc = 32;
  localparam int unsigned t_crdh_cyc = 32;
  localparam int unsigned t_rsh_cyc = 400000;
  localparam int unsigned t_pll_us = 100;
  localparam int unsigned t_tsh_us = 200;

  // derived cycle counts; least times round up, longest times round down
  localparam int unsigned t_cfgh_pll_cyc = t_cfgh_pll_us * clock_mhz;
  localparam int unsigned t_pll_cyc = t_pll_us * clock_mhz;
  localparam int unsigned t_tsh_cyc = t_tsh_us * clock_mhz;
  // device answers a read well inside the latency bound
  localparam int unsigned read_lat_cyc = 8;
  localparam int unsigned pll_lock_cyc = 64;

  typedef enum logic [1:0] {
    exit_plain,
    exit_odt,
    exit_pll
  } exit_kind_t;

  function automatic logic [cnt_w-1:0] exit_wait(input exit_kind_t k, input int unsigned pll_c);
    case (k)
      exit_odt: exit_wait = cnt_w'(t_cfgh_odt_cyc);
      exit_pll: exit_wait = cnt_w'(pll_c);
      default: exit_wait = cnt_w'(t_cfgh_cyc);
    endcase
  endfunction

endpackage

// *** design/cfg_link_if.sv ***
// pin-level link between memory controller and device
`timescale 1ns/1ps
`default_nettype none
interface cfg_link_if;
  import cfg_seq_pkg::*;
  logic cfg_select_n;
  logic port_a_load_strobe_n;
  logic port_a_write_n;
  logic [addr_w-1:0] address;
  logic [data_w-1:0] ctrl_data;
  logic ctrl_data_oe;
  logic [data_w-1:0] dev_data;
  logic dev_data_oe;
  logic [data_w-1:0] port_b_data_bus;
  logic [1:0] port_a_read_valid_strobe;
  logic dev_reset_n;
  logic test_reset_n;
  logic ctrl_ready;
  // resolved shared data bus
  logic [data_w-1:0] port_a_data_bus;
  assign port_a_data_bus = dev_data_oe ? dev_data : (ctrl_data_oe ? ctrl_data : '0);

  modport controller (
    output cfg_select_n, port_a_load_strobe_n, port_a_write_n, address, ctrl_data,
    output ctrl_data_oe, dev_reset_n, test_reset_n, port_b_data_bus,
    input port_a_data_bus, port_a_read_valid_strobe, ctrl_ready
  );
  modport device (
    input cfg_select_n, port_a_load_strobe_n, port_a_write_n, address, port_a_data_bus,
    input dev_reset_n, test_reset_n, port_b_data_bus,
    output dev_data, dev_data_oe, port_a_read_valid_strobe, ctrl_ready
  );
endinterface
`default_nettype wire

// *** design/cfg_ctrl_end.sv ***
// controller end: sequences config commands with all spacing waits
`timescale 1ns/1ps
`default_nettype none
module cfg_ctrl_end
  import cfg_seq_pkg::*;
#(
  parameter int unsigned rsh_cyc = t_rsh_cyc,
  parameter int unsigned pll_exit_cyc = t_cfgh_pll_cyc,
  parameter int unsigned tsh_cyc = t_tsh_cyc
)(
  input wire logic clock,
  input wire logic arst_n,
  cfg_link_if.controller link,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [addr_w-1:0] req_addr,
  input wire logic [cfg_w-1:0] req_wdata,
  input wire cfg_seq_pkg::exit_kind_t req_exit_kind,
  input wire logic req_last,
  output logic req_ready,
  output logic rsp_valid,
  output logic [cfg_w-1:0] rsp_rdata,
  output logic active_ok,
  output logic jtag_ok
);
  import cfg_seq_pkg::*;

  typedef enum logic [3:0] {
    s_boot, s_idle, s_enter, s_setup, s_addr, s_strobe, s_rdwait, s_hold, s_gap, s_leave,
    s_exit
  } state_t;

  state_t state;
  logic [cnt_w-1:0] cnt;
  logic [cnt_w-1:0] gap_cnt;
  logic [cnt_w-1:0] tck_cnt;
  logic wr;
  logic last;
  exit_kind_t kind;
  logic [addr_w-1:0] addr_q;
  logic [cfg_w-1:0] wdata_q;
  logic rdy_s1, rdy_s2;
  logic [1:0] vld_s1, vld_s2;
  logic [cfg_w-1:0] dat_s1, dat_s2;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      vld_s1 <= '0;
      vld_s2 <= '0;
      dat_s1 <= '0;
      dat_s2 <= '0;
      rdy_s1 <= 1'b0;
      rdy_s2 <= 1'b0;
    end
    else
    begin
      vld_s1 <= link.port_a_read_valid_strobe;
      vld_s2 <= vld_s1;
      dat_s1 <= link.port_a_data_bus[cfg_w-1:0];
      dat_s2 <= dat_s1;
      // lock flag comes from the far end, so it is synchronised like any pin
      rdy_s1 <= link.ctrl_ready;
      rdy_s2 <= rdy_s1;
    end
  end

  assign req_ready = (state == s_idle) || (state == s_gap && gap_cnt == '0);

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= s_boot;
      cnt <= '0;
      wr <= 1'b0;
      last <= 1'b0;
      kind <= exit_plain;
      addr_q <= '0;
      wdata_q <= '0;
      active_ok <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      if (cnt != '0)
        cnt <= cnt - 1'b1;
      case (state)
        s_boot:
          if (cnt == cnt_w'(rsh_cyc - 1))
          begin
            // also wait for the device to report lock
            if (rdy_s2)
            begin
              state <= s_idle;
              active_ok <= 1'b1;
              cnt <= '0;
            end
            else
              cnt <= cnt;
          end
          else
            cnt <= cnt + 1'b1;
        s_idle:
          if (req_valid)
          begin
            wr <= req_write;
            last <= req_last;
            kind <= req_exit_kind;
            // the requester may move on once taken, so address and data are kept here
            addr_q <= req_addr;
            wdata_q <= req_wdata;
            active_ok <= 1'b0;
            state <= s_enter;
            cnt <= cnt_w'(t_cfgs_cyc);
          end
        s_enter:
          if (cnt == '0)
          begin
            state <= s_addr;
            cnt <= cnt_w'(t_cfga_cyc);
          end
        s_addr:
          if (cnt == '0)
          begin
            state <= s_setup;
            cnt <= cnt_w'(t_clds_cyc - t_cfga_cyc);
          end
        s_setup:
          if (cnt == '0)
          begin
            state <= s_strobe;
            cnt <= cnt_w'(t_cldw_cyc);
          end
        s_strobe:
          if (cnt == '0)
          begin
            state <= wr ? s_hold : s_rdwait;
            cnt <= wr ? cnt_w'(t_cldh_cyc) : cnt_w'(t_crdl_cyc - t_cldw_cyc + 2);
          end
        s_rdwait:
          if (vld_s2[0])
          begin
            rsp_valid <= 1'b1;
            rsp_rdata <= dat_s2;
            state <= s_hold;
            cnt <= cnt_w'(t_cldh_cyc);
          end
          else if (cnt == '0)
          begin
            rsp_valid <= 1'b1;
            rsp_rdata <= '0;
            state <= s_hold;
            cnt <= cnt_w'(t_cldh_cyc);
          end
        s_hold:
          if (cnt == '0)
            state <= last ? s_leave : s_gap;
        s_gap:
          if (req_valid && gap_cnt == '0)
          begin
            wr <= req_write;
            last <= req_last;
            kind <= req_exit_kind;
            addr_q <= req_addr;
            wdata_q <= req_wdata;
            state <= s_addr;
            cnt <= '0;
          end
        s_leave:
          begin
            state <= s_exit;
            cnt <= exit_wait(kind, pll_exit_cyc);
          end
        s_exit:
          if (cnt == '0)
          begin
            state <= s_idle;
            active_ok <= 1'b1;
          end
        default:
          state <= s_boot;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // command spacing and test reset wait
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      gap_cnt <= '0;
    else if (state == s_setup && cnt == '0)
      gap_cnt <= cnt_w'(t_cfgd_cyc + t_clds_cyc - t_cfga_cyc);
    else if (gap_cnt != '0)
      gap_cnt <= gap_cnt - 1'b1;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tck_cnt <= '0;
      jtag_ok <= 1'b0;
    end
    else if (tck_cnt == cnt_w'(tsh_cyc - 1))
      jtag_ok <= 1'b1;
    else
      tck_cnt <= tck_cnt + 1'b1;
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  // select and strobe drive
  assign link.cfg_select_n = !(state inside {s_enter, s_addr, s_setup, s_strobe, s_rdwait,
                                             s_hold, s_gap, s_leave});
  assign link.port_a_load_strobe_n = (state != s_strobe);
  assign link.port_a_write_n = !wr;
  assign link.address = (state inside {s_setup, s_strobe}) ? addr_q : '0;
  assign link.ctrl_data = {{(data_w-cfg_w){1'b0}}, wdata_q};
  assign link.ctrl_data_oe = wr && (state == s_strobe);
  assign link.port_b_data_bus = '0;
  assign link.dev_reset_n = arst_n;
  assign link.test_reset_n = arst_n;

endmodule
`default_nettype wire

// *** design/cfg_dev_end.sv ***
// device end: configuration register store, read return and pll lock model
`timescale 1ns/1ps
`default_nettype none
module cfg_dev_end
  import cfg_seq_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  cfg_link_if.device link,
  output logic [cfg_w-1:0] cfg_regs [16],
  output logic pll_locked
);
  import cfg_seq_pkg::*;

  logic sel_s1, sel_s2, ld_s1, ld_s2, wn_s1, wn_s2, ld_d;
  logic [addr_w-1:0] a_s1, a_s2;
  logic [cfg_w-1:0] d_s1, d_s2;
  logic [cnt_w-1:0] lat_cnt, hold_cnt, pll_cnt;
  logic rd_pend;
  logic [3:0] rd_idx;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {sel_s1, sel_s2, ld_s1, ld_s2, wn_s1, wn_s2, ld_d} <= 7'h7f;
      a_s1 <= '0;
      a_s2 <= '0;
      d_s1 <= '0;
      d_s2 <= '0;
    end
    else
    begin
      sel_s1 <= link.cfg_select_n;
      sel_s2 <= sel_s1;
      ld_s1 <= link.port_a_load_strobe_n;
      ld_s2 <= ld_s1;
      ld_d <= ld_s2;
      wn_s1 <= link.port_a_write_n;
      wn_s2 <= wn_s1;
      a_s1 <= link.address;
      a_s2 <= a_s1;
      d_s1 <= link.port_a_data_bus[cfg_w-1:0];
      d_s2 <= d_s1;
    end
  end

  // ----------------------------------------------------------------
  // register store and read return
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < 16; i++)
        cfg_regs[i] <= '0;
      rd_pend <= 1'b0;
      rd_idx <= '0;
      lat_cnt <= '0;
      hold_cnt <= '0;
      link.dev_data <= '0;
      link.dev_data_oe <= 1'b0;
      link.port_a_read_valid_strobe <= '0;
    end
    else
    begin
      if (rd_pend && lat_cnt == '0)
      begin
        rd_pend <= 1'b0;
        link.dev_data <= {{(data_w-cfg_w){1'b0}}, cfg_regs[rd_idx]};
        link.dev_data_oe <= 1'b1;
        link.port_a_read_valid_strobe <= 2'h1;
        hold_cnt <= cnt_w'(t_crdh_cyc - 4);
      end
      else if (link.dev_data_oe && sel_s2)
      begin
        if (hold_cnt == '0)
        begin
          link.dev_data_oe <= 1'b0;
          link.port_a_read_valid_strobe <= '0;
        end
        else
          hold_cnt <= hold_cnt - 1'b1;
      end
      // placed last so a new read strobe wins over the clear of the old one
      if (!sel_s2 && ld_d && !ld_s2)
      begin
        if (!wn_s2)
          cfg_regs[a_s2[3:0]] <= d_s2;
        else
        begin
          rd_pend <= 1'b1;
          rd_idx <= a_s2[3:0];
          lat_cnt <= cnt_w'(read_lat_cyc);
        end
      end
      else if (rd_pend && lat_cnt != '0)
        lat_cnt <= lat_cnt - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // pll lock after reset
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pll_cnt <= '0;
      pll_locked <= 1'b0;
    end
    else if (pll_cnt == cnt_w'(pll_lock_cyc))
      pll_locked <= 1'b1;
    else
      pll_cnt <= pll_cnt + 1'b1;
  end

  assign link.ctrl_ready = pll_locked;

endmodule
`default_nettype wire

// *** tb/cfg_seq_chk.sv ***
// pin-level assertions on the controller to device configuration link
`timescale 1ns/1ps
`default_nettype none
module cfg_seq_chk
  import cfg_seq_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cfg_select_n,
  input wire logic port_a_load_strobe_n,
  input wire logic port_a_write_n,
  input wire logic [addr_w-1:0] address,
  input wire logic dev_data_oe,
  input wire logic [1:0] port_a_read_valid_strobe
);
  logic [15:0] sel_cnt;
  logic [15:0] lda_cnt;
  logic [15:0] hold_cnt;
  logic [15:0] cmd_cnt;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  function automatic logic [15:0] sat(input logic [15:0] x);
    return (x == 16'hffff) ? x : x + 16'h0001;
  endfunction
  // ----
  // cycle counters; saturating so long idle spans never wrap
  // ----
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n) sel_cnt <= '0;
    else sel_cnt <= cfg_select_n ? 16'h0000 : sat(sel_cnt);
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n) lda_cnt <= '0;
    else lda_cnt <= port_a_load_strobe_n ? 16'h0000 : sat(lda_cnt);
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n) hold_cnt <= 16'hffff;
    else hold_cnt <= port_a_load_strobe_n ? sat(hold_cnt) : 16'h0000;
  // distance from one strobe fall to the next
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n) cmd_cnt <= 16'hffff;
    else cmd_cnt <= (!port_a_load_strobe_n && lda_cnt == 16'h0000) ? 16'h0001 : sat(cmd_cnt);
  // ----
  // properties
  // ----
  sequence s_load;
    $fell(port_a_load_strobe_n);
  endsequence
  sequence s_read_load;
    $fell(port_a_load_strobe_n) && port_a_write_n;
  endsequence
  property p_sel_lead;
    s_load |-> sel_cnt >= 16'h0020;
  endproperty
  a_sel_lead: assert property (p_sel_lead) else $error("strobe too soon after select");
  property p_load_width;
    $rose(port_a_load_strobe_n) |-> lda_cnt >= 16'h0010;
  endproperty
  a_load_width: assert property (p_load_width) else $error("strobe pulse too short");
  property p_sel_trail;
    $rose(cfg_select_n) |-> hold_cnt >= 16'h0020;
  endproperty
  a_sel_trail: assert property (p_sel_trail) else $error("select released too soon");
  property p_cmd_gap;
    s_load |-> cmd_cnt >= 16'h0050;
  endproperty
  a_cmd_gap: assert property (p_cmd_gap) else $error("commands too close");
  property p_addr_late;
    $changed(address) |-> cfg_select_n || sel_cnt >= 16'h0010;
  endproperty
  a_addr_late: assert property (p_addr_late) else $error("address too early");
  property p_read_lat;
    s_read_load |-> ##[1:32] port_a_read_valid_strobe[0];
  endproperty
  a_read_lat: assert property (p_read_lat) else $error("read data late");
  property p_valid_align;
    $rose(port_a_read_valid_strobe[0]) |-> ##[0:2] dev_data_oe;
  endproperty
  a_valid_align: assert property (p_valid_align) else $error("valid not with data");
  property p_data_hold;
    $rose(cfg_select_n) |-> ##[0:32] !dev_data_oe;
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("read data held too long");
  property p_load_in_cfg;
    !port_a_load_strobe_n |-> !cfg_select_n;
  endproperty
  a_load_in_cfg: assert property (p_load_in_cfg) else $error("strobe outside select");
  property p_cfg_entry;
    !cfg_select_n && sel_cnt < 16'h0020 |-> port_a_load_strobe_n && address == '0;
  endproperty
  a_cfg_entry: assert property (p_cfg_entry) else $error("command inside entry wait");
endmodule
`default_nettype wire

// *** tb/sram_config_mode_sequencer_test.sv ***
// self-checking bench joining the controller and device ends
`timescale 1ns/1ps
`default_nettype none
module sram_config_mode_sequencer_test;
  import cfg_seq_pkg::*;
  localparam int unsigned rsh = 100;
  localparam int unsigned pll_x = 200;
  localparam int unsigned tsh = 50;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [addr_w-1:0] req_addr = '0;
  logic [cfg_w-1:0] req_wdata = '0;
  exit_kind_t req_exit_kind = exit_plain;
  logic req_last = 1'b0;
  logic req_ready;
  logic rsp_valid;
  logic [cfg_w-1:0] rsp_rdata;
  logic active_ok;
  logic jtag_ok;
  logic pll_locked;
  logic [cfg_w-1:0] regs [16];
  logic sel_q = 1'b1;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int rise_cyc = 0;
  int exp_wait [3];
  cfg_link_if u_cfg_link_if();
  cfg_ctrl_end #(.rsh_cyc(rsh), .pll_exit_cyc(pll_x), .tsh_cyc(tsh)) u_cfg_ctrl_end (
    .clock(clock), .arst_n(arst_n), .link(u_cfg_link_if.controller),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_exit_kind(req_exit_kind), .req_last(req_last),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .active_ok(active_ok), .jtag_ok(jtag_ok));
  cfg_dev_end u_cfg_dev_end (.clock(clock), .arst_n(arst_n), .link(u_cfg_link_if.device),
    .cfg_regs(regs), .pll_locked(pll_locked));
  cfg_seq_chk u_cfg_seq_chk (.clock(clock), .arst_n(arst_n),
    .cfg_select_n(u_cfg_link_if.cfg_select_n),
    .port_a_load_strobe_n(u_cfg_link_if.port_a_load_strobe_n),
    .port_a_write_n(u_cfg_link_if.port_a_write_n), .address(u_cfg_link_if.address),
    .dev_data_oe(u_cfg_link_if.dev_data_oe),
    .port_a_read_valid_strobe(u_cfg_link_if.port_a_read_valid_strobe));
  initial
  begin
    forever #5 clock = ~clock;
  end
  // ----
  // select release monitor, the start of every exit wait
  // ----
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    sel_q <= u_cfg_link_if.cfg_select_n;
    if (u_cfg_link_if.cfg_select_n === 1'b1 && sel_q === 1'b0)
      rise_cyc <= cyc;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check_data(input logic [cfg_w-1:0] got, input logic [cfg_w-1:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_flag(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_min(input int got, input int lo);
    n_checks++;
    if (got < lo)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected at least %h", $time, got, lo);
    end
  endtask
  // request held until the edge at which ready is seen
  task automatic cmd(input logic wr, input logic [addr_w-1:0] a, input logic [cfg_w-1:0] d,
                     input exit_kind_t k, input logic last);
    int n;
    n = 0;
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    req_exit_kind <= k;
    req_last <= last;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (req_ready !== 1'b1 && n < 6000);
    req_valid <= 1'b0;
    check_flag(req_ready, 1'b1);
  endtask
  task automatic rd(input logic [addr_w-1:0] a, input logic [cfg_w-1:0] exp, input logic last);
    int n;
    n = 0;
    cmd(1'b0, a, 8'h00, exit_plain, last);
    do
    begin
      @(posedge clock);
      n++;
    end
    while (rsp_valid !== 1'b1 && n < 200);
    check_flag(rsp_valid, 1'b1);
    check_data(rsp_rdata, exp);
  endtask
  task automatic wait_active(input int lo);
    int n;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (active_ok !== 1'b1 && n < 8000);
    check_flag(active_ok, 1'b1);
    check_min(cyc - rise_cyc, lo);
  endtask
  initial
  begin
    #300000;
    error_cnt++;
    summarize();
  end
  // ----
  // tests
  // ----
  initial
  begin
    int n;
    int tj;
    exp_wait = '{t_cfgh_cyc, t_cfgh_odt_cyc, pll_x};
    n = 0;
    tj = 0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
      if (jtag_ok === 1'b1 && tj == 0)
        tj = n;
    end
    while (active_ok !== 1'b1 && n < 1000);
    check_min(n, rsh);
    check_min(tj, tsh);
    check_flag(pll_locked, 1'b1);
    $display("test reset done");
    // upper address bits fall outside the register index
    cmd(1'b1, 14'h3ff3, 8'ha5, exit_plain, 1'b0);
    rd(14'h0003, 8'ha5, 1'b1);
    wait_active(t_cfgh_cyc);
    check_data(regs[3], 8'ha5);
    $display("test write_read done");
    for (int k = 0; k < 3; k++)
    begin
      cmd(1'b1, 14'(5 + k), 8'(8'h5a ^ k), exit_kind_t'(k), 1'b1);
      wait_active(exp_wait[k]);
      check_data(regs[5 + k], 8'(8'h5a ^ k));
    end
    $display("test exits done");
    for (int k = 0; k < 3; k++)
      rd(14'(5 + k), 8'(8'h5a ^ k), k == 2);
    wait_active(t_cfgh_cyc);
    $display("test readback done");
    summarize();
  end
endmodule
`default_nettype wire
